// >>> bench/iars_chk.sv
// Purpose: Port checks for iars_regs.
// Assumes: One clock domain; rst_b is active low.
// Notes: The lock flag is judged only once the pin has been still for six cycles.
`timescale 1ns/1ps
module iars_chk #(parameter [2:0] REVISION = 3'h0) (
  input wire       sys_clk, rst_b, reg_wr, reg_rd, rx_lock_pin, learn_valid, crc_err,
  input wire       req_valid, fwd_valid_q, ctrl_clr_q,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata_q,
  input wire [6:0] learn_addr, req_addr, fwd_addr_q
);
  wire st = reg_rd && reg_addr == 8'h0C;
  wire cr = reg_rd && reg_addr == 8'h0A && ctrl_clr_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_fwd_src: assert property (fwd_valid_q |-> $past(req_valid)) else $error("stray fwd");
  a_zero_blk: assert property (req_valid && !req_addr |=> !fwd_valid_q)
    else $error("zero fwd");
  a_fwd_hold: assert property (!fwd_valid_q |-> $stable(fwd_addr_q)) else $error("addr");
  a_clr_keep: assert property (!(reg_wr && reg_addr == 8'h03) |=> $stable(ctrl_clr_q))
    else $error("clr moved");
  a_clr_cnt: assert property (cr && $past(ctrl_clr_q) |=> !reg_rdata_q) else $error("cnt");
  a_rev_fld: assert property (st |=> reg_rdata_q[7:5] == REVISION) else $error("rev");
  a_lock_flg: assert property ($stable(rx_lock_pin)[*6] ##0 st |=> reg_rdata_q[4] == $past(rx_lock_pin))
    else $error("lock");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata_q)) else $error("rdata");
  c_fwd: cover property (fwd_valid_q);
  c_learn: cover property (learn_valid);
  c_clr_err: cover property (ctrl_clr_q && crc_err);
endmodule // iars_chk
bind iars_regs iars_chk #(.REVISION(REVISION)) u_chk (.*);

// >>> bench/iars_far.sv
// Purpose: Far side model: loads the bridge address after lock and sends CRC errors.
// Assumes: The bench drives lock and error requests.
// Notes: Address lines show the inverse value outside the learn pulse.
`timescale 1ns/1ps
module iars_far #(parameter [6:0] ADDR = 7'h2A) (
  input  wire       sys_clk, rx_lock_pin, inject,
  output reg        learn_valid, crc_err,
  output wire [6:0] learn_addr
);
  reg [7:0] sh_q = 8'h00;
  assign learn_addr = learn_valid ? ADDR : ~ADDR;
  always @(posedge sys_clk) begin
    sh_q <= {sh_q[6:0], rx_lock_pin};
    learn_valid <= sh_q[7:6] == 2'h1;
    crc_err <= inject;
  end
endmodule // iars_far

// >>> bench/iars_regs_tb_top.sv
// Purpose: Directed bench for iars_regs.
// Assumes: Strobes are one-cycle pulses; answers settle just after the taking edge.
// Notes: Status bit 3 belongs to other logic and is masked.
`timescale 1ns/1ps
module iars_regs_tb_top;
  reg        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
  reg        rx_lock_pin = 1'b0, inject = 1'b0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  reg  [6:0] req_addr = 7'h00;
  wire [7:0] reg_rdata_q;
  wire [6:0] learn_addr, fwd_addr_q;
  wire       learn_valid, crc_err, fwd_valid_q, ctrl_clr_q;
  integer    bad_count = 0, checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  iars_far u_far (.*);
  iars_regs #(.REVISION(3'h5)) DUT (.*);
  // Kind 1 reads, 2 writes, 3 sends a request, 0 idles two cycles.
  task op(input [1:0] k, input [7:0] a, input [7:0] d, input [7:0] e);
    reg [7:0] got;
    {reg_rd, reg_wr, req_valid} <= {k == 2'h1, k == 2'h2, k == 2'h3};
    {reg_addr, reg_wdata, req_addr} <= {a, d, a[6:0]};
    @(posedge sys_clk);
    {reg_rd, reg_wr, req_valid} <= 3'h0;
    #1;
    got = k[1] ? {fwd_valid_q, e[7] ? fwd_addr_q : 7'h00} : reg_rdata_q & {4'hF, a != 8'h0C, 3'h7};
    if (k[0]) checks_done = checks_done + 1;
    if (k[0] && got !== e) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t addr %h got %h expected %h", $time, a, got, e);
    end
    @(posedge sys_clk);
  endtask
  task wrap_up;
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    op(1, 8'h07, 0, 0); op(1, 8'h08, 0, 0); op(1, 8'h09, 0, 0); op(1, 8'h0A, 0, 0);
    rx_lock_pin <= 1'b1;
    repeat (12) @(posedge sys_clk);
    op(1, 8'h0C, 0, 8'hB0); op(1, 8'h06, 0, 8'h54);
    op(2, 8'h07, 8'h40, 0); op(3, 8'h20, 0, 8'hAA);
    op(2, 8'h07, 0, 0); op(3, 8'h20, 0, 0); op(3, 8'h00, 0, 0);
    op(2, 8'h08, 8'h64, 0); op(2, 8'h09, 8'h22, 0); op(3, 8'h11, 0, 8'hB2);
    op(2, 8'h08, 0, 0); op(3, 8'h11, 0, 0);
    op(2, 8'h06, 8'h33, 0); rx_lock_pin <= 1'b0; op(0, 0, 0, 0); op(1, 8'h0C, 0, 8'hA0);
    rx_lock_pin <= 1'b1; repeat (12) @(posedge sys_clk); op(1, 8'h06, 0, 8'h33);
    inject <= 1'b1; repeat (3) @(posedge sys_clk); inject <= 1'b0; op(0, 0, 0, 0);
    op(1, 8'h0A, 0, 8'h03); op(2, 8'h0A, 8'hFF, 0); op(1, 8'h0A, 0, 8'h03);
    op(1, 8'h0B, 0, 0); op(2, 8'h03, 8'h20, 0); op(1, 8'h03, 0, 8'h20);
    inject <= 1'b1; op(0, 0, 0, 0); inject <= 1'b0; op(1, 8'h0A, 0, 0);
    op(2, 8'h03, 0, 0); inject <= 1'b1; @(posedge sys_clk); inject <= 1'b0;
    op(0, 0, 0, 0); op(1, 8'h0A, 0, 8'h01); op(1, 8'h30, 0, 0);
    wrap_up;
  end
endmodule // iars_regs_tb_top

// >>> inc/iars_defines.vh
// Purpose: Constants for the alias remap and status register bank.
// Assumes: 8-bit registers on a byte-wide internal register port.
// Notes: Offsets are byte addresses on that port.
//
// Contract
// RULE_01 - Local address equal to bridge alias is remapped to the remote bridge address.
// RULE_02 - A zero bridge alias blocks forwarding through the bridge alias path.
// RULE_03 - Far-target address holds the slave address that matching transactions get.
// RULE_04 - Far-target alias matches are remapped; zero in either far field blocks.
// RULE_05 - Back-channel CRC errors count in 16 bits, low byte 0x0A, high 0x0B.
// RULE_06 - Counters held cleared while control bit 5 is one; software clears it.
// RULE_07 - On receive lock the bridge address auto-loads unless the hold bit is set.
// RULE_08 - Status bit 4 shows receive lock; bits 7 to 5 show the revision field.
`ifndef IARS_DEFINES_VH
`define IARS_DEFINES_VH

`define IARS_OFS_CTRL        8'h03
`define IARS_OFS_BRIDGE_ADDR 8'h06
`define IARS_OFS_ALIAS       8'h07
`define IARS_OFS_FAR_ADDR    8'h08
`define IARS_OFS_FAR_ALIAS   8'h09
`define IARS_OFS_CRC_LO      8'h0A
`define IARS_OFS_CRC_HI      8'h0B
`define IARS_OFS_STATUS      8'h0C

`define IARS_CTRL_CLR_BIT    5
`define IARS_HOLD_BIT        0
`define IARS_LOCK_BIT        4
`define IARS_REV_LSB         5

`define IARS_RST_BYTE        8'h00
`define IARS_RST_CNT         16'h0000

`endif

// >>> verilog/iars_cnt16.v
// Purpose: Saturating 16-bit event counter with a held clear.
// Assumes: Events are single-cycle pulses on sys_clk.
// Notes: Saturates instead of wrapping so a full count is never mistaken for few errors.
`timescale 1ns/1ps
`include "iars_defines.vh"
module iars_cnt16 (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        clr,
  input  wire        evt,
  output reg  [15:0] count_q
);
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `IARS_RST_CNT;
    end else if (clr) begin
      count_q <= `IARS_RST_CNT; // RULE_06
    end else if (evt && (count_q != 16'hFFFF)) begin
      count_q <= count_q + 16'h0001; // RULE_05
    end
  end
endmodule // iars_cnt16

// >>> verilog/iars_regs.v
// Purpose: Alias remap registers, CRC error counter and general status.
// Assumes: Register port is byte-wide and synchronous to sys_clk.
// Notes: Address matching is combinational into a registered remap result.
`timescale 1ns/1ps
`include "iars_defines.vh"
module iars_regs #(
  parameter [2:0] REVISION = 3'h0 // Arbitrary value.
) (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire       rx_lock_pin,
  input  wire       learn_valid,
  input  wire [6:0] learn_addr,
  input  wire       crc_err,
  input  wire       req_valid,
  input  wire [6:0] req_addr,
  output reg        fwd_valid_q,
  output reg  [6:0] fwd_addr_q,
  output reg        ctrl_clr_q
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg  [7:0] bridge_q;
  reg  [7:0] alias_q;
  reg  [7:0] far_q;
  reg  [7:0] far_alias_q;
  reg        lock_m_q;
  reg        lock_q;
  wire [15:0] crc_cnt;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  iars_cnt16 u_cnt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clr     (ctrl_clr_q),
    .evt     (crc_err),
    .count_q (crc_cnt)
  );

  // Lock comes from a pin, so it is synchronised before use.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_m_q <= 1'b0;
      lock_q   <= 1'b0;
    end else begin
      lock_m_q <= rx_lock_pin;
      lock_q   <= lock_m_q;
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // One strobe and one offset select each writable register.
  function wr_sel;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_sel = wr && (addr == ofs);
    end
  endfunction

  // Bit 0 of the alias and far-target registers is reserved and is always stored as zero.
  function [7:0] addr_field;
    input [7:0] data;
    begin
      addr_field = {data[7:1], 1'h0};
    end
  endfunction

  wire wr_ctrl      = wr_sel(reg_wr, reg_addr, `IARS_OFS_CTRL);
  wire wr_bridge    = wr_sel(reg_wr, reg_addr, `IARS_OFS_BRIDGE_ADDR);
  wire wr_alias     = wr_sel(reg_wr, reg_addr, `IARS_OFS_ALIAS);
  wire wr_far       = wr_sel(reg_wr, reg_addr, `IARS_OFS_FAR_ADDR);
  wire wr_far_alias = wr_sel(reg_wr, reg_addr, `IARS_OFS_FAR_ALIAS);

  // Learning is only trusted while the receiver is locked and software has not
  // frozen the bridge address.
  wire learn_take   = lock_q && learn_valid && !bridge_q[`IARS_HOLD_BIT];

  // The clear bit is a plain level; it stays set until software writes it back.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_clr_q <= 1'h0;
    end else if (wr_ctrl) begin
      ctrl_clr_q <= reg_wdata[`IARS_CTRL_CLR_BIT]; // RULE_06
    end
  end

  // A software write wins over an auto-load in the same cycle, so a value written
  // together with the hold bit can never be lost to a late learn pulse.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bridge_q <= `IARS_RST_BYTE;
    end else if (wr_bridge) begin
      bridge_q <= reg_wdata;
    end else if (learn_take) begin
      bridge_q <= {learn_addr, 1'h0}; // RULE_07
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alias_q <= `IARS_RST_BYTE;
    end else if (wr_alias) begin
      alias_q <= addr_field(reg_wdata); // RULE_01
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      far_q <= `IARS_RST_BYTE;
    end else if (wr_far) begin
      far_q <= addr_field(reg_wdata); // RULE_03
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      far_alias_q <= `IARS_RST_BYTE;
    end else if (wr_far_alias) begin
      far_alias_q <= addr_field(reg_wdata); // RULE_04
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // The counter halves are not latched together, so a read pair taken while errors
  // arrive may mix two counts; read both while the link is quiet.
  function [7:0] rd_mux;
    input [7:0]  addr;
    input        clr;
    input [7:0]  bridge;
    input [7:0]  alias_val;
    input [7:0]  far;
    input [7:0]  far_alias;
    input [15:0] cnt;
    input        lock;
    begin
      case (addr)
        `IARS_OFS_CTRL:        rd_mux = {2'h0, clr, 5'h00};
        `IARS_OFS_BRIDGE_ADDR: rd_mux = bridge;
        `IARS_OFS_ALIAS:       rd_mux = alias_val;
        `IARS_OFS_FAR_ADDR:    rd_mux = far;
        `IARS_OFS_FAR_ALIAS:   rd_mux = far_alias;
        `IARS_OFS_CRC_LO:      rd_mux = cnt[7:0]; // RULE_05
        `IARS_OFS_CRC_HI:      rd_mux = cnt[15:8]; // RULE_05
        `IARS_OFS_STATUS:      rd_mux = {REVISION, lock, 4'h0}; // RULE_08
        default:               rd_mux = `IARS_RST_BYTE;
      endcase
    end
  endfunction

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= `IARS_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux(reg_addr, ctrl_clr_q, bridge_q, alias_q, far_q,
                            far_alias_q, crc_cnt, lock_q);
    end
  end

  // ------------------------------------------------------------
  // Alias remap
  // ------------------------------------------------------------
  // An alias only matches when both it and its target are nonzero, so a cleared
  // register closes its path instead of forwarding to address zero.
  function alias_match;
    input [6:0] req;
    input [6:0] alias_val;
    input [6:0] target;
    begin
      alias_match = (alias_val != 7'h00) && (target != 7'h00) && (req == alias_val);
    end
  endfunction

  wire bridge_hit = alias_match(req_addr, alias_q[7:1], bridge_q[7:1]); // RULE_01 RULE_02
  wire far_hit    = alias_match(req_addr, far_alias_q[7:1], far_q[7:1]); // RULE_04

  reg       fwd_valid_d;
  reg [6:0] fwd_addr_d;

  // The bridge path wins when both aliases hold the same address.
  always @* begin
    fwd_valid_d = req_valid && (bridge_hit || far_hit);
    fwd_addr_d  = fwd_addr_q;
    if (req_valid && bridge_hit) begin
      fwd_addr_d = bridge_q[7:1]; // RULE_01
    end else if (req_valid && far_hit) begin
      fwd_addr_d = far_q[7:1]; // RULE_03
    end
  end

  // ------------------------------------------------------------
  // Forward outputs
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_valid_q <= 1'h0;
      fwd_addr_q  <= 7'h00;
    end else begin
      fwd_valid_q <= fwd_valid_d;
      fwd_addr_q  <= fwd_addr_d;
    end
  end
endmodule // iars_regs
